// File: rtl/pbmwd_pkg.sv
/*
  Types shared by the memory window decoder files.
  Assumes pbmwd_regs.svh is on the include path.
*/
`include "pbmwd_regs.svh"

package pbmwd_pkg;
  typedef logic [11:0] pbmwd_field_t;
  typedef logic [63:0] pbmwd_addr_t;
  typedef enum logic [3:0] {
    PBMWD_IORD = `PBMWD_C_IORD,
    PBMWD_IOWR = `PBMWD_C_IOWR,
    PBMWD_MRD = `PBMWD_C_MRD,
    PBMWD_MWR = `PBMWD_C_MWR,
    PBMWD_MRM = `PBMWD_C_MRM,
    PBMWD_MRL = `PBMWD_C_MRL,
    PBMWD_MWI = `PBMWD_C_MWI
  } pbmwd_cmd_t;
endpackage

// File: rtl/pbmwd_regs.svh
/*
  Configuration offsets, field fills, reset values and bus command codes
  of the memory window decoder. Assumes dword-aligned configuration
  accesses with byte enables, as a PCI configuration cycle delivers them.
*/
`ifndef PBMWD_REGS_SVH
`define PBMWD_REGS_SVH

// ----------------------------------------------------------------------
// Configuration offsets (byte addresses)
// ----------------------------------------------------------------------
`define PBMWD_CMD_OFF 8'h04
`define PBMWD_NP_BASE_OFF 8'h20
`define PBMWD_NP_LIMIT_OFF 8'h22
`define PBMWD_PF_BASE_OFF 8'h24
`define PBMWD_PF_LIMIT_OFF 8'h28
`define PBMWD_PF_BASE_HI_OFF 8'h40
`define PBMWD_PF_LIMIT_HI_OFF 8'h44

// ----------------------------------------------------------------------
// Command register bits
// ----------------------------------------------------------------------
`define PBMWD_CMD_IO_EN_BIT 0
`define PBMWD_CMD_MEM_EN_BIT 1
`define PBMWD_CMD_MASTER_EN_BIT 2
`define PBMWD_CMD_W 3

// ----------------------------------------------------------------------
// Window fields
// ----------------------------------------------------------------------
`define PBMWD_NP_LOW_NIB 4'h0
`define PBMWD_PF_LOW_NIB 4'h1
`define PBMWD_BASE_FILL 20'h00000
`define PBMWD_LIMIT_FILL 20'hfffff
`define PBMWD_BASE_RST 12'h000
`define PBMWD_LIMIT_RST 12'h000
`define PBMWD_HI_RST 32'h00000000
`define PBMWD_VGA_LO 32'h000a0000
`define PBMWD_VGA_HI 32'h000bffff

// ----------------------------------------------------------------------
// Bus command codes
// ----------------------------------------------------------------------
`define PBMWD_C_IORD 4'h2
`define PBMWD_C_IOWR 4'h3
`define PBMWD_C_MRD 4'h6
`define PBMWD_C_MWR 4'h7
`define PBMWD_C_MRM 4'hc
`define PBMWD_C_MRL 4'he
`define PBMWD_C_MWI 4'hf

`endif

// File: rtl/pbmwd_top.sv
/*
  Memory window decoder of a bridge: configuration registers for the
  nonprefetchable and prefetchable windows, primary and secondary claim
  decisions and read prefetch policy.
  Assumes bus inputs are synchronous to i_clock and that the I/O range
  decoder supplies i_sec_io_outside. Results appear one cycle after valid.
*/
// Functional notes
// RULE_01 - Downstream memory forwarding needs memory enable
// RULE_02 - Upstream forwarding needs bus master enable
// RULE_03 - Software programs windows before enables, idle buses
// RULE_04 - Nonprefetchable: prefetch only line, multiple reads
// RULE_05 - Nonprefetchable hit: claim primary, ignore secondary
// RULE_06 - Outside all windows: claim secondary only
// RULE_07 - Nonprefetchable window 32-bit, 1 MB granular
// RULE_08 - Nonprefetchable registers: bits 31:20, low zero
// RULE_09 - Nonprefetchable base zero-filled, limit ones-filled
// RULE_10 - Nonprefetchable window resets to lowest 1 MB
// RULE_11 - Base above limit disables nonprefetchable window
// RULE_12 - Prefetchable window prefetches all memory reads; code stays cautious where it overlaps nonprefetchable or VGA
// RULE_13 - Prefetchable hit: claim primary, ignore secondary
// RULE_14 - Single address cycle has zero upper bits
// RULE_15 - Single cycles pass only if upper base zero
// RULE_16 - Prefetchable window 1 MB granular
// RULE_17 - Prefetchable registers: bits 31:20, low 1h
// RULE_18 - Prefetchable base zero-filled, limit ones-filled
// RULE_19 - Prefetchable window resets to lowest 1 MB
// RULE_20 - Full 64-bit compare disables prefetchable window
// RULE_21 - Inclusive hits against registered configuration
`timescale 1ns/1ps
`include "pbmwd_regs.svh"

module pbmwd_top (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Configuration access
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_rdata,
  // VGA memory forwarding
  input wire logic i_vga_mode,
  // Primary bus transaction
  input wire logic i_pri_valid,
  input wire logic [3:0] i_pri_cmd,
  input wire logic i_pri_dac,
  input wire logic [31:0] i_pri_addr,
  input wire logic [31:0] i_pri_addr_hi,
  output logic o_pri_claim,
  output logic o_pri_prefetch,
  output logic o_pri_single,
  // Secondary bus transaction
  input wire logic i_sec_valid,
  input wire logic [3:0] i_sec_cmd,
  input wire logic i_sec_dac,
  input wire logic [31:0] i_sec_addr,
  input wire logic [31:0] i_sec_addr_hi,
  input wire logic i_sec_io_outside,
  output logic o_sec_claim,
  // Enables, for the rest of the bridge
  output logic o_mem_en,
  output logic o_master_en
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_OFF = `PBMWD_CMD_OFF;
  localparam logic [7:0] NP_B_OFF = `PBMWD_NP_BASE_OFF;
  localparam logic [7:0] NP_L_OFF = `PBMWD_NP_LIMIT_OFF;
  localparam logic [7:0] PF_B_OFF = `PBMWD_PF_BASE_OFF;
  localparam logic [7:0] PF_L_OFF = `PBMWD_PF_LIMIT_OFF;
  localparam logic [7:0] PF_BH_OFF = `PBMWD_PF_BASE_HI_OFF;
  localparam logic [7:0] PF_LH_OFF = `PBMWD_PF_LIMIT_HI_OFF;

  logic [`PBMWD_CMD_W-1:0] cmd_q;
  pbmwd_pkg::pbmwd_field_t np_base_q;
  pbmwd_pkg::pbmwd_field_t np_limit_q;
  pbmwd_pkg::pbmwd_field_t pf_base_q;
  pbmwd_pkg::pbmwd_field_t pf_limit_q;
  logic [31:0] pf_base_hi_q;
  logic [31:0] pf_limit_hi_q;
  logic mem_en;
  logic master_en;
  logic wr_cmd, wr_np, wr_pf_b, wr_pf_l, wr_pf_bh, wr_pf_lh;
  pbmwd_pkg::pbmwd_addr_t pri_addr64;
  pbmwd_pkg::pbmwd_addr_t sec_addr64;
  pbmwd_pkg::pbmwd_addr_t np_base64;
  pbmwd_pkg::pbmwd_addr_t np_limit64;
  pbmwd_pkg::pbmwd_addr_t pf_base64;
  pbmwd_pkg::pbmwd_addr_t pf_limit64;
  logic np_pri_hit, pf_pri_hit, np_sec_hit, pf_sec_hit;
  logic vga_pri_hit, vga_sec_hit;
  logic pri_mem, pri_read, pri_line;
  logic sec_mem, sec_io;
  logic next_pri_claim;
  logic next_pri_prefetch;
  logic next_sec_claim;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------------
  // Byte-lane write helpers
  // ----------------------------------------------------------------------
  function automatic pbmwd_pkg::pbmwd_field_t fld_wr(
    input pbmwd_pkg::pbmwd_field_t old,
    input logic [15:0] d,
    input logic [1:0] be
  );
    pbmwd_pkg::pbmwd_field_t v;
    v = old;
    // Low nibble of the low byte is fixed and never stored
    if (be[0]) begin
      v[3:0] = d[7:4];
    end
    if (be[1]) begin
      v[11:4] = d[15:8];
    end
    return v;
  endfunction

  function automatic logic [31:0] word_wr(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0] be
  );
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        v[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  assign wr_cmd = i_cfg_wr && (i_cfg_addr[7:2] == CMD_OFF[7:2]);
  assign wr_np = i_cfg_wr && (i_cfg_addr[7:2] == NP_B_OFF[7:2]);
  assign wr_pf_b = i_cfg_wr && (i_cfg_addr[7:2] == PF_B_OFF[7:2]);
  assign wr_pf_l = i_cfg_wr && (i_cfg_addr[7:2] == PF_L_OFF[7:2]);
  assign wr_pf_bh = i_cfg_wr && (i_cfg_addr[7:2] == PF_BH_OFF[7:2]);
  assign wr_pf_lh = i_cfg_wr && (i_cfg_addr[7:2] == PF_LH_OFF[7:2]);

  // ----------------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cmd_q <= '0;
    end else if (wr_cmd && i_cfg_be[0]) begin
      cmd_q <= i_cfg_wdata[`PBMWD_CMD_W-1:0];
    end
  end

  assign mem_en = cmd_q[`PBMWD_CMD_MEM_EN_BIT];
  assign master_en = cmd_q[`PBMWD_CMD_MASTER_EN_BIT];
  assign o_mem_en = mem_en;
  assign o_master_en = master_en;

  // ----------------------------------------------------------------------
  // Nonprefetchable window registers
  // ----------------------------------------------------------------------
  // Base and limit share one dword; limit sits in the upper lanes
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      np_base_q <= `PBMWD_BASE_RST; // RULE_10
      np_limit_q <= `PBMWD_LIMIT_RST; // RULE_10
    end else if (wr_np) begin
      np_base_q <= fld_wr(np_base_q, i_cfg_wdata[15:0], i_cfg_be[1:0]);
      np_limit_q <= fld_wr(np_limit_q, i_cfg_wdata[31:16], i_cfg_be[3:2]);
    end
  end

  // ----------------------------------------------------------------------
  // Prefetchable window registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pf_base_q <= `PBMWD_BASE_RST; // RULE_19
      pf_limit_q <= `PBMWD_LIMIT_RST; // RULE_19
    end else begin
      if (wr_pf_b) begin
        pf_base_q <= fld_wr(pf_base_q, i_cfg_wdata[15:0], i_cfg_be[1:0]);
      end
      if (wr_pf_l) begin
        pf_limit_q <= fld_wr(pf_limit_q, i_cfg_wdata[15:0], i_cfg_be[1:0]);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pf_base_hi_q <= `PBMWD_HI_RST;
      pf_limit_hi_q <= `PBMWD_HI_RST;
    end else begin
      if (wr_pf_bh) begin
        pf_base_hi_q <= word_wr(pf_base_hi_q, i_cfg_wdata, i_cfg_be);
      end
      if (wr_pf_lh) begin
        pf_limit_hi_q <= word_wr(pf_limit_hi_q, i_cfg_wdata, i_cfg_be);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration read
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    case (i_cfg_addr[7:2])
      CMD_OFF[7:2]: next_rdata[`PBMWD_CMD_W-1:0] = cmd_q;
      NP_B_OFF[7:2]: next_rdata = {np_limit_q, `PBMWD_NP_LOW_NIB,
                                   np_base_q, `PBMWD_NP_LOW_NIB}; // RULE_08
      PF_B_OFF[7:2]: next_rdata[15:0] = {pf_base_q,
                                         `PBMWD_PF_LOW_NIB}; // RULE_17
      PF_L_OFF[7:2]: next_rdata[15:0] = {pf_limit_q,
                                         `PBMWD_PF_LOW_NIB}; // RULE_17
      PF_BH_OFF[7:2]: next_rdata = pf_base_hi_q;
      PF_LH_OFF[7:2]: next_rdata = pf_limit_hi_q;
      default: next_rdata = '0;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_cfg_rdata <= '0;
    end else if (i_cfg_rd) begin
      o_cfg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Window bounds
  // ----------------------------------------------------------------------
  // Nonprefetchable bounds never reach above 4 GB
  assign np_base64 = {32'h0, np_base_q, `PBMWD_BASE_FILL}; // RULE_07 RULE_09
  assign np_limit64 = {32'h0, np_limit_q, `PBMWD_LIMIT_FILL}; // RULE_09
  assign pf_base64 = {pf_base_hi_q, pf_base_q,
                      `PBMWD_BASE_FILL}; // RULE_16 RULE_18 RULE_20
  assign pf_limit64 = {pf_limit_hi_q, pf_limit_q,
                       `PBMWD_LIMIT_FILL}; // RULE_18 RULE_20

  // Single address cycles compare with zero upper bits
  assign pri_addr64 = {i_pri_dac ? i_pri_addr_hi : 32'h0,
                       i_pri_addr}; // RULE_14 RULE_15
  assign sec_addr64 = {i_sec_dac ? i_sec_addr_hi : 32'h0,
                       i_sec_addr}; // RULE_14

  // ----------------------------------------------------------------------
  // Window comparators
  // ----------------------------------------------------------------------
  pbmwd_win_if np_pri_if ();
  pbmwd_win_if pf_pri_if ();
  pbmwd_win_if np_sec_if ();
  pbmwd_win_if pf_sec_if ();

  assign np_pri_if.base = np_base64;
  assign np_pri_if.limit = np_limit64;
  assign np_pri_if.addr = pri_addr64;
  assign pf_pri_if.base = pf_base64;
  assign pf_pri_if.limit = pf_limit64;
  assign pf_pri_if.addr = pri_addr64;
  assign np_sec_if.base = np_base64;
  assign np_sec_if.limit = np_limit64;
  assign np_sec_if.addr = sec_addr64;
  assign pf_sec_if.base = pf_base64;
  assign pf_sec_if.limit = pf_limit64;
  assign pf_sec_if.addr = sec_addr64;

  pbmwd_window #(.AW(64)) u_np_pri (.win(np_pri_if));
  pbmwd_window #(.AW(64)) u_pf_pri (.win(pf_pri_if));
  pbmwd_window #(.AW(64)) u_np_sec (.win(np_sec_if));
  pbmwd_window #(.AW(64)) u_pf_sec (.win(pf_sec_if));

  assign np_pri_hit = np_pri_if.hit; // RULE_11 RULE_21
  assign pf_pri_hit = pf_pri_if.hit; // RULE_20 RULE_21
  assign np_sec_hit = np_sec_if.hit;
  assign pf_sec_hit = pf_sec_if.hit;

  assign vga_pri_hit = i_vga_mode && !i_pri_dac &&
                       (i_pri_addr >= `PBMWD_VGA_LO) &&
                       (i_pri_addr <= `PBMWD_VGA_HI);
  assign vga_sec_hit = i_vga_mode && !i_sec_dac &&
                       (i_sec_addr >= `PBMWD_VGA_LO) &&
                       (i_sec_addr <= `PBMWD_VGA_HI);

  // ----------------------------------------------------------------------
  // Command classes
  // ----------------------------------------------------------------------
  assign pri_read = (i_pri_cmd == pbmwd_pkg::PBMWD_MRD) ||
                    (i_pri_cmd == pbmwd_pkg::PBMWD_MRM) ||
                    (i_pri_cmd == pbmwd_pkg::PBMWD_MRL);
  assign pri_line = (i_pri_cmd == pbmwd_pkg::PBMWD_MRM) ||
                    (i_pri_cmd == pbmwd_pkg::PBMWD_MRL);
  assign pri_mem = pri_read || (i_pri_cmd == pbmwd_pkg::PBMWD_MWR) ||
                   (i_pri_cmd == pbmwd_pkg::PBMWD_MWI);
  assign sec_mem = (i_sec_cmd == pbmwd_pkg::PBMWD_MRD) ||
                   (i_sec_cmd == pbmwd_pkg::PBMWD_MRM) ||
                   (i_sec_cmd == pbmwd_pkg::PBMWD_MRL) ||
                   (i_sec_cmd == pbmwd_pkg::PBMWD_MWR) ||
                   (i_sec_cmd == pbmwd_pkg::PBMWD_MWI);
  assign sec_io = (i_sec_cmd == pbmwd_pkg::PBMWD_IORD) ||
                  (i_sec_cmd == pbmwd_pkg::PBMWD_IOWR);

  // ----------------------------------------------------------------------
  // Claim and prefetch decisions
  // ----------------------------------------------------------------------
  assign next_pri_claim = i_pri_valid && pri_mem && mem_en &&
                          (np_pri_hit || pf_pri_hit ||
                           vga_pri_hit); // RULE_01 RULE_05 RULE_13 RULE_06

  // Overlap with the nonprefetchable or VGA range falls back to the
  // cautious policy; reads there may have side effects
  assign next_pri_prefetch = next_pri_claim && pri_read &&
                             ((pf_pri_hit && !np_pri_hit && !vga_pri_hit) ||
                              (np_pri_hit && pri_line)); // RULE_04 RULE_12

  assign next_sec_claim = i_sec_valid && master_en &&
                          ((sec_mem && !np_sec_hit && !pf_sec_hit &&
                            !vga_sec_hit) ||
                           (sec_io && i_sec_io_outside)); // RULE_02 RULE_06

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_pri_claim <= 1'b0;
      o_pri_prefetch <= 1'b0;
      o_pri_single <= 1'b0;
    end else begin
      o_pri_claim <= next_pri_claim;
      o_pri_prefetch <= next_pri_prefetch;
      o_pri_single <= next_pri_claim && pri_read &&
                      !next_pri_prefetch; // RULE_04
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_sec_claim <= 1'b0;
    end else begin
      o_sec_claim <= next_sec_claim; // RULE_05 RULE_13
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  mem_en_gate_a: // RULE_01
    assert property (o_pri_claim |-> $past(mem_en))
    else $error("primary claim without memory enable");

  master_gate_a: // RULE_02
    assert property (o_sec_claim |-> $past(master_en))
    else $error("secondary claim without master enable");

  np_read_single_a: // RULE_04
    assert property ((i_pri_valid && mem_en && np_pri_hit &&
      i_pri_cmd == pbmwd_pkg::PBMWD_MRD) |=> (o_pri_single &&
      !o_pri_prefetch))
    else $error("plain read in nonprefetchable window not single");

  np_line_pref_a: // RULE_04
    assert property ((i_pri_valid && mem_en && np_pri_hit && pri_line)
      |=> (o_pri_claim && o_pri_prefetch && !o_pri_single))
    else $error("line read in nonprefetchable window not prefetched");

  np_claim_a: // RULE_05
    assert property ((i_pri_valid && mem_en && pri_mem && np_pri_hit)
      ##1 (i_sec_valid && sec_mem && np_sec_hit) |-> o_pri_claim ##1
      !o_sec_claim)
    else $error("nonprefetchable window claim wrong");

  outside_a: // RULE_06
    assert property ((i_sec_valid && master_en && sec_mem &&
      !np_sec_hit && !pf_sec_hit && !vga_sec_hit) |=> o_sec_claim)
    else $error("outside address not forwarded upstream");

  np_low_zero_a: // RULE_08
    assert property ((i_cfg_rd && i_cfg_addr[7:2] == NP_B_OFF[7:2]) |=>
      (o_cfg_rdata[3:0] == `PBMWD_NP_LOW_NIB &&
       o_cfg_rdata[19:16] == `PBMWD_NP_LOW_NIB &&
       o_cfg_rdata[31:20] == $past(np_limit_q)))
    else $error("nonprefetchable register read wrong");

  pf_low_one_a: // RULE_17
    assert property ((i_cfg_rd && i_cfg_addr[7:2] == PF_B_OFF[7:2]) |=>
      (o_cfg_rdata[3:0] == `PBMWD_PF_LOW_NIB &&
       o_cfg_rdata[15:4] == $past(pf_base_q)))
    else $error("prefetchable base read wrong");

  reset_window_a: // RULE_10 RULE_19
    assert property (!$past(i_rst_n) |-> (np_base64[31:0] == 32'h0 &&
      np_limit64[31:0] == 32'h000fffff && pf_base64 == 64'h0 &&
      pf_limit64 == 64'h000fffff))
    else $error("window not lowest 1 MB after reset");

  np_disabled_a: // RULE_11
    assert property ((np_base_q > np_limit_q) |-> !np_pri_hit)
    else $error("disabled nonprefetchable window hit");

  pf_pref_a: // RULE_12 RULE_13
    assert property ((i_pri_valid && mem_en && pri_read && pf_pri_hit &&
      !np_pri_hit && !vga_pri_hit) |=> (o_pri_claim && o_pri_prefetch))
    else $error("prefetchable read not prefetched");

  sac_upper_a: // RULE_15
    assert property ((!i_pri_dac && pf_base_hi_q != 32'h0) |-> !pf_pri_hit)
    else $error("single cycle hit with nonzero upper base");

  pf_disable_a: // RULE_20
    assert property (({pf_base_hi_q, pf_base_q} >
      {pf_limit_hi_q, pf_limit_q}) |-> !pf_pri_hit)
    else $error("disabled prefetchable window hit");

  inclusive_a: // RULE_21
    assert property ((np_base_q <= np_limit_q && !i_pri_dac &&
      (i_pri_addr == np_base64[31:0] || i_pri_addr == np_limit64[31:0]))
      |-> np_pri_hit)
    else $error("window bounds not inclusive");

endmodule

// File: rtl/pbmwd_win_if.sv
/*
  One window comparison: full 64-bit bounds, address in, hit out.
  Assumes the bounds are already expanded to byte addresses.
*/
`timescale 1ns/1ps

interface pbmwd_win_if;
  pbmwd_pkg::pbmwd_addr_t base;
  pbmwd_pkg::pbmwd_addr_t limit;
  pbmwd_pkg::pbmwd_addr_t addr;
  logic hit;
  modport cmp (input base, input limit, input addr, output hit);
  modport user (output base, output limit, output addr, input hit);
endinterface

// File: rtl/pbmwd_window.sv
/*
  Inclusive base/limit comparator for one window.
  Assumes one clock domain; purely combinational.
*/
`timescale 1ns/1ps

module pbmwd_window #(
  parameter int AW = 64
) (
  // Window
  pbmwd_win_if.cmp win
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (AW != 64) begin : g_bad_aw
    $error("pbmwd_window supports 64-bit addresses only");
  end

  // ----------------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------------
  // Base above limit yields no hit, which is how a window is turned off
  assign win.hit = (win.base <= win.addr) && (win.addr <= win.limit); // RULE_21

endmodule

// File: testbench/pbmwd_bus_model.sv
/*
  Far side of the decoder: configuration master plus the primary and
  secondary initiators. Assumes callers enter tasks just after an edge.
*/
`timescale 1ns/1ps

module pbmwd_bus_model (
  // Clock
  input wire logic i_clock,
  // Configuration master
  output logic i_cfg_wr,
  output logic i_cfg_rd,
  output logic [7:0] i_cfg_addr,
  output logic [3:0] i_cfg_be,
  output logic [31:0] i_cfg_wdata,
  // Initiators
  output logic i_pri_valid,
  output logic i_pri_dac,
  output logic [3:0] i_pri_cmd,
  output logic [31:0] i_pri_addr,
  output logic [31:0] i_pri_addr_hi,
  output logic i_sec_valid,
  output logic i_sec_dac,
  output logic [3:0] i_sec_cmd,
  output logic [31:0] i_sec_addr,
  output logic [31:0] i_sec_addr_hi
);
  initial begin
    {i_cfg_wr, i_cfg_rd, i_cfg_addr, i_cfg_be, i_cfg_wdata} = '0;
    {i_pri_valid, i_pri_dac, i_pri_cmd, i_pri_addr, i_pri_addr_hi} = '0;
    {i_sec_valid, i_sec_dac, i_sec_cmd, i_sec_addr, i_sec_addr_hi} = '0;
  end
  // Strobe left up; the next call or req overwrites it once
  task automatic cfg(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    {i_pri_valid, i_sec_valid} = 2'b00;
    {i_cfg_wr, i_cfg_rd, i_cfg_addr, i_cfg_be} = {w, !w, a, 4'hf};
    i_cfg_wdata = d;
    @(posedge i_clock);
    #1;
  endtask
  // Dual address only when the upper half is nonzero
  task automatic req(input logic pv, sv, input logic [3:0] pc, sc,
    input logic [63:0] pa, sa);
    {i_cfg_wr, i_cfg_rd} = 2'b00;
    {i_pri_valid, i_pri_cmd, i_pri_dac} = {pv, pc, |pa[63:32]};
    {i_pri_addr_hi, i_pri_addr} = pa;
    {i_sec_valid, i_sec_cmd, i_sec_dac} = {sv, sc, |sa[63:32]};
    {i_sec_addr_hi, i_sec_addr} = sa;
  endtask
endmodule

// File: testbench/testbench.sv
/*
  Self-checking bench of the memory window decoder.
  Assumes pbmwd_top and pbmwd_bus_model are compiled before it.
*/
`timescale 1ns/1ps

module testbench;
  logic i_clock, i_rst_n, i_vga_mode, i_sec_io_outside;
  logic i_cfg_wr, i_cfg_rd, i_pri_valid, i_pri_dac, i_sec_valid, i_sec_dac;
  logic [7:0] i_cfg_addr;
  logic [3:0] i_cfg_be, i_pri_cmd, i_sec_cmd;
  logic [31:0] i_cfg_wdata, o_cfg_rdata, i_pri_addr, i_pri_addr_hi;
  logic [31:0] i_sec_addr, i_sec_addr_hi;
  logic o_pri_claim, o_pri_prefetch, o_pri_single, o_sec_claim;
  logic o_mem_en, o_master_en;
  int err_count, cmp_count, cyc;
  logic [11:0] nb = '0, nl = '0, pb = '0, pl = '0;
  logic [31:0] bh = '0, lh = '0;
  logic [2:0] cm = '0;
  logic [3:0] cmds [8] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'he, 4'hf, 4'h1};

  pbmwd_top dut (.*);
  pbmwd_bus_model bus (.*);

  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (e !== g) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Returns claim, prefetch, single, policy-checkable
  function automatic logic [3:0] pred(input logic s, input logic [3:0] c,
    input logic [63:0] a);
    logic mem, rd, np, pf, vg;
    mem = c inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf};
    rd = c inside {4'h6, 4'hc, 4'he};
    np = a[63:32] == 0 && a[31:0] >= {nb, 20'h0};
    np = np && a[31:0] <= {nl, 20'hfffff};
    pf = a >= {bh, pb, 20'h0} && a <= {lh, pl, 20'hfffff};
    vg = i_vga_mode && a >= 64'ha0000 && a <= 64'hbffff;
    if (s) begin
      return {ben(c) && mem && !(np || pf || vg) ||
        ben(c) && c inside {4'h2, 4'h3} && i_sec_io_outside, 3'b000};
    end
    return {cm[1] && mem && (np || pf || vg), vg ? 2'b01 : np ?
      {c != 4'h6, c == 4'h6} : 2'b10, rd && !(vg && np)};
  endfunction

  function automatic logic ben(input logic [3:0] c);
    return cm[2];
  endfunction

  // Bounds and the VGA hole are hit far more often than pure chance
  function automatic logic [63:0] pick();
    logic [19:0] t [4];
    t = '{20'h0, 20'hfffff, 20'ha0000 | 17'($urandom), 20'($urandom)};
    return {31'h0, 1'($urandom), 8'h0, 4'($urandom), t[$urandom_range(0, 3)]};
  endfunction

  task automatic rdall;
    logic [7:0] a [7] = '{8'h04, 8'h20, 8'h24, 8'h28, 8'h40, 8'h44, 8'h80};
    logic [31:0] e [7];
    e = '{{29'h0, cm}, {nl, 4'h0, nb, 4'h0}, {16'h0, pb, 4'h1},
      {16'h0, pl, 4'h1}, bh, lh, 32'h0};
    foreach (a[i]) begin
      bus.cfg(0, a[i], 32'($urandom));
      chk("cfg_rdata", e[i], o_cfg_rdata);
    end
    chk("enables", cm[2:1], {o_master_en, o_mem_en});
  endtask

  task automatic traffic;
    logic [63:0] pa, sa;
    logic [3:0] pc, sc, ep, es;
    repeat (12) begin
      pa = pick();
      sa = pick();
      pc = cmds[$urandom_range(0, 7)];
      sc = cmds[$urandom_range(0, 7)];
      i_sec_io_outside = 1'($urandom);
      bus.req(1, 1, pc, sc, pa, sa);
      ep = pred(0, pc, pa);
      es = pred(1, sc, sa);
      @(posedge i_clock);
      #1;
      chk("pri_claim", ep[3], o_pri_claim);
      if (ep[3] && ep[0]) begin
        chk("pri_policy", ep[2:1], {o_pri_prefetch, o_pri_single});
      end
      chk("sec_claim", es[3], o_sec_claim);
    end
    bus.req(0, 0, 4'h0, 4'h0, ~pa, ~sa);
    @(posedge i_clock);
    #1;
    chk("idle_claim", 0, {o_pri_claim, o_sec_claim});
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    i_clock = 0;
    forever #5 i_clock = ~i_clock;
  end

  // Hang guard, over three times the expected run
  always @(posedge i_clock) begin
    cyc++;
    if (cyc > 3000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(32'hdb374749));
    {i_rst_n, i_vga_mode, i_sec_io_outside} = 3'b000;
    repeat (4) @(posedge i_clock);
    #1;
    i_rst_n = 1;
    rdall();
    cm = 3'b010;
    bus.cfg(1, 8'h04, 32'h2);
    traffic();
    repeat (30) begin
      {nb[3:0], nl[3:0], pb[3:0], pl[3:0]} = 16'($urandom);
      {bh[0], lh[0], cm} = 5'($urandom);
      bus.cfg(1, 8'h04, 32'h0);
      bus.cfg(1, 8'h20, {nl, 4'hf, nb, 4'hf});
      bus.cfg(1, 8'h24, {16'hffff, pb, 4'he});
      bus.cfg(1, 8'h28, {16'hffff, pl, 4'he});
      bus.cfg(1, 8'h40, bh);
      bus.cfg(1, 8'h44, lh);
      bus.cfg(1, 8'h80, 32'hffffffff);
      i_vga_mode = 1'($urandom);
      bus.cfg(1, 8'h04, 32'(cm));
      rdall();
      traffic();
    end
    // Mid-run reset must drop the programmed windows and enables
    i_rst_n = 0;
    repeat (2) @(posedge i_clock);
    #1;
    i_rst_n = 1;
    {nb, nl, pb, pl, bh, lh, cm} = '0;
    rdall();
    cm = 3'b110;
    bus.cfg(1, 8'h04, 32'h6);
    traffic();
    report_and_stop();
  end
endmodule
